// ---- design/ascp_axis.sv ----
`timescale 1ns/1ps
module ascp_axis #(
  parameter int MS_DIV      = ascp_pkg::MS_CYCLES,
  parameter int STILL_STEPS = ascp_pkg::STILL_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Parameter access
  input  wire logic [7:0]  param_num,
  input  wire logic        param_wr,
  input  wire logic        param_rd,
  input  wire logic [31:0] param_wdata,
  output logic      [31:0] param_rdata,
  output logic             param_ack,
  // Motion state
  input  wire logic [7:0]  run_current,
  input  wire logic        ramp_phase,
  input  wire logic        velocity_zero,
  input  wire logic        motion_cmd,
  input  wire logic        step_pulse,
  // Error sources
  input  wire logic        stall_event,
  input  wire logic        deviation_event,
  input  wire logic [9:0]  load_value,
  input  wire logic [6:0]  driver_status,
  // Encoder
  input  wire logic        enc_step,
  input  wire logic        enc_dir,
  // Motor drive
  output logic      [7:0]  motor_current,
  output logic             motor_power
);
  import ascp_pkg::*;

  localparam int SW = $clog2(STILL_STEPS + 1);
  localparam logic [SW-1:0] STILL_LIM = SW'(STILL_STEPS);

  logic [7:0]  boost_current;
  logic [15:0] freewheel_delay;
  logic [9:0]  load_measurement;
  logic [1:0]  motion_error_flags;
  logic [7:0]  driver_error_flags;
  logic [31:0] encoder_count;
  logic [31:0] encoder_divider;
  logic [15:0] still_ms;
  logic [SW-1:0] step_idle;
  logic        ms_tick;

  ascp_tick #(.DIV(MS_DIV)) u_ms (
    .clock (clock),
    .rst_b (rst_b),
    .tick  (ms_tick)
  );

  wire wr_boost = param_wr && (param_num == PN_BOOST_CURRENT);
  wire wr_free  = param_wr && (param_num == PN_FREEWHEEL_DELAY);
  wire wr_enc   = param_wr && (param_num == PN_ENCODER_COUNT);
  wire wr_div   = param_wr && (param_num == PN_ENCODER_DIVIDER);
  wire rd_err   = param_rd && (param_num == PN_MOTION_ERR_FLAGS);

  wire [7:0] next_motor_current =
    (ramp_phase && boost_current != 8'h00) ? boost_current : run_current;
  wire       cut_due = (freewheel_delay != 16'h0000) && velocity_zero
                       && (still_ms >= freewheel_delay);
  wire       next_motor_power = !cut_due;
  wire [1:0] err_set = {deviation_event, stall_event};
  wire [1:0] next_motion_error_flags =
    ((rd_err || motion_cmd) ? 2'h0 : motion_error_flags) | err_set;
  wire       standstill = (step_idle == STILL_LIM);
  // Bits 0..6 mirror the driver, bit 7 is the local standstill detector
  wire [7:0] next_driver_error_flags =
    {standstill, driver_status};
  wire [31:0] enc_delta = enc_dir ? 32'hFFFFFFFF : 32'h00000001;
  wire [31:0] next_encoder_count =
    wr_enc ? param_wdata : (enc_step ? encoder_count + enc_delta : encoder_count);

  logic [31:0] rd_mux;
  always_comb begin
    unique case (param_num)
      PN_BOOST_CURRENT:    rd_mux = {24'h000000, boost_current};
      PN_FREEWHEEL_DELAY:  rd_mux = {16'h0000, freewheel_delay};
      PN_LOAD_MEASUREMENT: rd_mux = {22'h0, load_measurement};
      PN_MOTION_ERR_FLAGS: rd_mux = {30'h0, motion_error_flags};
      PN_DRIVER_ERR_FLAGS: rd_mux = {24'h000000, driver_error_flags};
      PN_ENCODER_COUNT:    rd_mux = encoder_count;
      PN_ENCODER_DIVIDER:  rd_mux = encoder_divider;
      default:             rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      boost_current   <= RST_BOOST_CURRENT;
      freewheel_delay <= RST_FREEWHEEL_DELAY;
      encoder_divider <= RST_ENCODER_DIVIDER;
      encoder_count   <= RST_ENCODER_COUNT;
    end else begin
      if (wr_boost) boost_current <= param_wdata[7:0];
      if (wr_free) freewheel_delay <= param_wdata[15:0];
      if (wr_div) encoder_divider <= param_wdata;
      encoder_count <= next_encoder_count;
    end
  end

  // Millisecond standstill count, restarted by any movement
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      still_ms <= 16'h0000;
    end else if (!velocity_zero) begin
      still_ms <= 16'h0000;
    end else if (ms_tick && still_ms != STILL_MS_MAX) begin
      still_ms <= still_ms + 16'h0001;
    end
  end

  // Cycles since the last step pulse, saturating
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      step_idle <= '0;
    end else if (step_pulse) begin
      step_idle <= '0;
    end else if (!standstill) begin
      step_idle <= step_idle + SW'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      load_measurement   <= 10'h000;
      motion_error_flags <= 2'h0;
      driver_error_flags <= 8'h00;
      motor_current      <= 8'h00;
      motor_power        <= 1'b1;
      param_rdata        <= 32'h00000000;
      param_ack          <= 1'b0;
    end else begin
      load_measurement   <= load_value;
      motion_error_flags <= next_motion_error_flags;
      driver_error_flags <= next_driver_error_flags;
      motor_current      <= next_motor_current;
      motor_power        <= next_motor_power;
      param_ack          <= param_rd || param_wr;
      if (param_rd) param_rdata <= rd_mux;
    end
  end

  sequence s_ramp_boost;
    ramp_phase && boost_current != 8'h00;
  endsequence

  property p_boost_used;
    @(posedge clock) disable iff (!rst_b)
      s_ramp_boost |=> motor_current == $past(boost_current);
  endproperty
  a_boost_used: assert property (p_boost_used) else $error("boost not applied");

  property p_zero_boost;
    @(posedge clock) disable iff (!rst_b)
      (boost_current == 8'h00 || !ramp_phase) |=> motor_current == $past(run_current);
  endproperty
  a_zero_boost: assert property (p_zero_boost) else $error("run current not applied");

  property p_power_cut;
    @(posedge clock) disable iff (!rst_b)
      (velocity_zero && freewheel_delay != 16'h0000 && still_ms >= freewheel_delay)
        |=> !motor_power;
  endproperty
  a_power_cut: assert property (p_power_cut) else $error("power not cut");

  property p_never_cut;
    @(posedge clock) disable iff (!rst_b)
      (freewheel_delay == 16'h0000) |=> motor_power;
  endproperty
  a_never_cut: assert property (p_never_cut) else $error("power cut with zero delay");

  property p_load_read;
    @(posedge clock) disable iff (!rst_b)
      (param_rd && param_num == PN_LOAD_MEASUREMENT)
        |=> param_rdata == {22'h0, $past(load_measurement)};
  endproperty
  a_load_read: assert property (p_load_read) else $error("load readout wrong");

  property p_err_set;
    @(posedge clock) disable iff (!rst_b)
      stall_event && deviation_event |=> motion_error_flags == 2'h3;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flags not set");

  sequence s_err_clear;
    (rd_err || motion_cmd) && !stall_event && !deviation_event;
  endsequence

  property p_err_clear;
    @(posedge clock) disable iff (!rst_b)
      s_err_clear |=> motion_error_flags == 2'h0;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flags not cleared");

  property p_drv_mirror;
    @(posedge clock) disable iff (!rst_b)
      1'b1 |=> driver_error_flags[6:1] == $past(driver_status[6:1]);
  endproperty
  a_drv_mirror: assert property (p_drv_mirror) else $error("driver bits not mirrored");

  property p_step_clears_still;
    @(posedge clock) disable iff (!rst_b)
      step_pulse |=> ##1 !driver_error_flags[DRV_STANDSTILL];
  endproperty
  a_step_clears_still: assert property (p_step_clears_still)
    else $error("standstill after step");

  property p_enc_write;
    @(posedge clock) disable iff (!rst_b)
      wr_enc |=> encoder_count == $past(param_wdata);
  endproperty
  a_enc_write: assert property (p_enc_write) else $error("encoder not loaded");
endmodule

// ---- design/ascp_pkg.sv ----
package ascp_pkg;
  // Parameter numbers
  localparam logic [7:0] PN_BOOST_CURRENT    = 8'hC8;
  localparam logic [7:0] PN_FREEWHEEL_DELAY  = 8'hCC;
  localparam logic [7:0] PN_LOAD_MEASUREMENT = 8'hCE;
  localparam logic [7:0] PN_MOTION_ERR_FLAGS = 8'hCF;
  localparam logic [7:0] PN_DRIVER_ERR_FLAGS = 8'hD0;
  localparam logic [7:0] PN_ENCODER_COUNT    = 8'hD1;
  localparam logic [7:0] PN_ENCODER_DIVIDER  = 8'hD2;
  // Reset values
  localparam logic [7:0]  RST_BOOST_CURRENT   = 8'h00;
  localparam logic [15:0] RST_FREEWHEEL_DELAY = 16'h0000;
  localparam logic [31:0] RST_ENCODER_COUNT   = 32'h00000000;
  localparam logic [31:0] RST_ENCODER_DIVIDER = 32'h00000000;
  // Motion error field positions
  localparam int ERR_STALL_BIT     = 0;
  localparam int ERR_DEVIATION_BIT = 1;
  // Driver status field positions
  localparam int DRV_STALL_BIT     = 0;
  localparam int DRV_OTEMP_BIT     = 1;
  localparam int DRV_OTEMP_WARN    = 2;
  localparam int DRV_SHORT_A_BIT   = 3;
  localparam int DRV_SHORT_B_BIT   = 4;
  localparam int DRV_OPEN_A_BIT    = 5;
  localparam int DRV_OPEN_B_BIT    = 6;
  localparam int DRV_STANDSTILL    = 7;
  // Timing
  localparam int CLK_PERIOD_NS     = 50;
  localparam int MS_TIME_NS        = 1000000;
  localparam int MS_CYCLES         = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int STILL_STEP_CYCLES = 1 << 20;
  localparam logic [15:0] STILL_MS_MAX = 16'hFFFF;
endpackage

// ---- design/ascp_tick.sv ----
`timescale 1ns/1ps
// One-cycle enable pulse every DIV clock cycles
module ascp_tick #(
  parameter int DIV = 20000
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Enable out
  output logic      tick
);
  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt;
  wire          wrap = (cnt == LAST);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= wrap ? '0 : cnt + W'(1);
      tick <= wrap;
    end
  end
endmodule

// ---- testbench/ascp_far_model.sv ----
`timescale 1ns/1ps
// Motor driver, motor and encoder seen from the axis block
module ascp_far_model (
  // Clock
  input  wire logic       clock,
  // Bench commands
  input  wire logic [6:0] set_status,
  input  wire logic [9:0] set_load,
  input  wire logic       f_stall,
  input  wire logic       f_dev,
  input  wire logic       enc_go,
  input  wire logic       enc_down,
  input  wire logic       step_go,
  // Driver and encoder outputs
  output logic      [6:0] driver_status,
  output logic      [9:0] load_value,
  output logic            stall_event,
  output logic            deviation_event,
  output logic            enc_step,
  output logic            enc_dir,
  output logic            step_pulse
);
  // Everything changes only at the clock edge, one cycle after the command
  always @(posedge clock) begin
    driver_status   <= set_status;
    load_value      <= set_load;
    stall_event     <= f_stall;
    deviation_event <= f_dev;
    enc_step        <= enc_go;
    enc_dir         <= enc_down;
    step_pulse      <= step_go;
  end
endmodule

// ---- testbench/test_axis_status_current_params.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, a, b); end end
module test_axis_status_current_params;
  import ascp_pkg::*;
  localparam int MS_SIM    = 10;
  localparam int STILL_SIM = 16;
  logic        clock         = 1'b0;
  logic        rst_b         = 1'b0;
  logic        param_wr      = 1'b0;
  logic        param_rd      = 1'b0;
  logic        ramp_phase    = 1'b0;
  logic        velocity_zero = 1'b0;
  logic        motion_cmd    = 1'b0;
  logic        f_stall       = 1'b0;
  logic        f_dev         = 1'b0;
  logic        enc_go        = 1'b0;
  logic        enc_down      = 1'b0;
  logic        step_go       = 1'b0;
  logic [7:0]  param_num     = 8'h00;
  logic [7:0]  run_current   = 8'h00;
  logic [31:0] param_wdata   = 32'h00000000;
  logic [6:0]  set_status    = 7'h00;
  logic [9:0]  set_load      = 10'h000;
  logic [7:0]  motor_current;
  logic [31:0] param_rdata;
  logic [6:0]  driver_status;
  logic [9:0]  load_value;
  logic        param_ack;
  logic        motor_power;
  logic        stall_event;
  logic        deviation_event;
  logic        enc_step;
  logic        enc_dir;
  logic        step_pulse;
  logic [31:0] v;
  logic [32:0] note;
  int          miscompares   = 0;
  int          comparisons   = 0;
  int          n;
  // Bit 32 of a note marks a read whose data is compared
  logic [32:0] expq[$];
  logic [7:0]  pn[4]         = '{PN_BOOST_CURRENT, PN_FREEWHEEL_DELAY,
                                 PN_ENCODER_COUNT, PN_ENCODER_DIVIDER};
  logic [31:0] msk[4]        = '{32'h000000FF, 32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};

  ascp_axis #(.MS_DIV(MS_SIM), .STILL_STEPS(STILL_SIM)) u_ascp_axis (.clock, .rst_b, .param_num,
    .param_wr, .param_rd, .param_wdata, .param_rdata, .param_ack, .run_current, .ramp_phase,
    .velocity_zero, .motion_cmd, .step_pulse, .stall_event, .deviation_event, .load_value,
    .driver_status, .enc_step, .enc_dir, .motor_current, .motor_power);
  ascp_far_model u_ascp_far_model (.clock, .set_status, .set_load, .f_stall, .f_dev, .enc_go,
    .enc_down, .step_go, .driver_status, .load_value, .stall_event, .deviation_event,
    .enc_step, .enc_dir, .step_pulse);

  task automatic cyc(int k);
    repeat (k) @(posedge clock);
    #5;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    expq.push_back({1'b0, 32'h00000000});
    cyc(1);
    param_wr = 1'b1;
    param_num = a;
    param_wdata = d;
    cyc(1);
    param_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expq.push_back({1'b1, e});
    cyc(1);
    param_rd = 1'b1;
    param_num = a;
    cyc(1);
    param_rd = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic test_done;
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Every acknowledge retires the oldest note; read notes also compare the data
  always @(negedge clock) begin
    if (param_ack === 1'b1) begin
      if (expq.size() == 0) begin
        `CHK(1'b0, 1'b1)
      end else begin
        note = expq.pop_front();
        if (note[32]) `CHK(param_rdata, note[31:0])
      end
    end
  end

  initial forever #25 clock = ~clock;
  initial begin
    void'($urandom(32'h9304F293));
    repeat (6) @(posedge clock);
    #5;
    rst_b = 1'b1;
    rd(PN_BOOST_CURRENT, 32'h00000000);
    rd(PN_FREEWHEEL_DELAY, 32'h00000000);
    rd(8'h00, 32'h00000000);
    foreach (pn[i]) begin
      v = $urandom;
      wr(pn[i], v);
      rd(pn[i], v & msk[i]);
    end
    // Read-only load value ignores a write of different data
    set_load = 10'($urandom);
    wr(PN_LOAD_MEASUREMENT, {22'h0, ~set_load});
    rd(PN_LOAD_MEASUREMENT, {22'h0, set_load});
    // Current selection during ramps
    run_current = 8'($urandom_range(127, 1));
    ramp_phase = 1'b1;
    wr(PN_BOOST_CURRENT, 32'h00000000);
    cyc(2);
    `CHK(motor_current, run_current)
    v = $urandom_range(255, 128);
    wr(PN_BOOST_CURRENT, v);
    cyc(2);
    `CHK(motor_current, v[7:0])
    ramp_phase = 1'b0;
    cyc(2);
    `CHK(motor_current, run_current)
    // Standstill power cut; the ms tick phase is free, so one period of slack
    wr(PN_FREEWHEEL_DELAY, 32'h00000000);
    velocity_zero = 1'b1;
    cyc(200);
    `CHK(motor_power, 1'b1)
    velocity_zero = 1'b0;
    wr(PN_FREEWHEEL_DELAY, 32'h00000003);
    velocity_zero = 1'b1;
    n = 0;
    while (motor_power !== 1'b0 && n < 60) begin
      cyc(1);
      n++;
    end
    `CHK(n >= 2 * MS_SIM + 2 && n <= 3 * MS_SIM + 1, 1'b1)
    velocity_zero = 1'b0;
    cyc(2);
    `CHK(motor_power, 1'b1)
    // Motion error flags
    pulse(f_stall);
    cyc(2);
    rd(PN_MOTION_ERR_FLAGS, 32'h00000001);
    rd(PN_MOTION_ERR_FLAGS, 32'h00000000);
    pulse(f_dev);
    cyc(2);
    rd(PN_MOTION_ERR_FLAGS, 32'h00000002);
    f_stall = 1'b1;
    f_dev = 1'b1;
    cyc(1);
    f_stall = 1'b0;
    f_dev = 1'b0;
    cyc(2);
    rd(PN_MOTION_ERR_FLAGS, 32'h00000003);
    pulse(f_dev);
    cyc(2);
    pulse(motion_cmd);
    cyc(1);
    rd(PN_MOTION_ERR_FLAGS, 32'h00000000);
    // Driver status mirror, one bit at a time, standstill set
    for (int b = 0; b < 7; b++) begin
      set_status = 7'(1 << b);
      cyc(2);
      rd(PN_DRIVER_ERR_FLAGS, {24'h0, 1'b1, set_status});
    end
    set_status = 7'($urandom);
    pulse(step_go);
    cyc(3);
    rd(PN_DRIVER_ERR_FLAGS, {24'h0, 1'b0, set_status});
    cyc(STILL_SIM + 14);
    rd(PN_DRIVER_ERR_FLAGS, {24'h0, 1'b1, set_status});
    // Encoder counts up three and down one from a loaded value
    v = $urandom;
    wr(PN_ENCODER_COUNT, v);
    enc_go = 1'b1;
    cyc(3);
    enc_down = 1'b1;
    cyc(1);
    enc_go = 1'b0;
    enc_down = 1'b0;
    cyc(3);
    rd(PN_ENCODER_COUNT, v + 32'h00000002);
    n = 0;
    while (expq.size() > 0 && n < 10) begin
      cyc(1);
      n++;
    end
    `CHK(expq.size(), 0)
    test_done();
  end
endmodule
